// [design/spp_port.sv]
/*
  Six-pin general purpose port with direction, analog select, weak pull-ups
  and interrupt-on-change, reached over AHB-Lite.
  Assumes pins are resolved outside from PIN_OUT/PIN_OE/PULLUP_EN, and that
  SRST is asserted for every reset kind with POR_RESET high only for power-on.
  Pin changes reach reads and the change compare four edges late.

*/
`include "spp_cfg.svh"
`default_nettype none

module spp_port
  import spp_pkg::*;
#(
  parameter int NUM_PINS = 6
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                SRST,
  input  wire logic                POR_RESET,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output var  logic [31:0]         HRDATA,
  output var  logic                HREADYOUT,
  output var  logic                HRESP,
  // Configuration word inputs
  input  wire logic                MASTER_CLEAR_ENABLE,
  input  wire logic [2:0]          OSC_MODE,
  // Package pins
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output var  logic [NUM_PINS-1:0] PIN_OUT,
  output var  logic [NUM_PINS-1:0] PIN_OE,
  output var  logic [NUM_PINS-1:0] PULLUP_EN,
  // Interrupt and wake requests
  output var  logic                PORT_INT_REQ,
  output var  logic                WAKE_REQ
);

  // --------------------------------------------------------------------------
  // Mode decoding
  // --------------------------------------------------------------------------
  // Oscillator modes that take both clock pins away from the port
  function automatic logic osc_uses_two_pins(input spp_osc_e mode);
    osc_uses_two_pins = (mode == SPP_OSC_LOW_POWER) || (mode == SPP_OSC_CRYSTAL) ||
                        (mode == SPP_OSC_HIGH_SPEED);
  endfunction : osc_uses_two_pins

  // Oscillator modes that take only the clock input pin
  function automatic logic osc_uses_one_pin(input spp_osc_e mode);
    osc_uses_one_pin = (mode == SPP_OSC_RC) || (mode == SPP_OSC_RC_WITH_IO) ||
                       (mode == SPP_OSC_EXT_CLOCK);
  endfunction : osc_uses_one_pin

  wire spp_osc_e osc_mode = spp_osc_e'(OSC_MODE);
  wire two_pin_osc = osc_uses_two_pins(osc_mode);
  wire one_pin_osc = osc_uses_one_pin(osc_mode);
  // Crystal-family modes take pins five and four; RC and external clock modes take pin five only
  wire [NUM_PINS-1:0] osc_two_mask = two_pin_osc ? 6'h30 : 6'h00;
  wire [NUM_PINS-1:0] osc_one_mask = one_pin_osc ? 6'h20 : 6'h00;

  // --------------------------------------------------------------------------
  // Front end and pin synchroniser
  // --------------------------------------------------------------------------
  spp_regbus_if rb ();

  spp_ahb_slave u_ahb (
    .clk       (CLK),
    .srst      (SRST),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .rb        (rb.bus)
  );

  // Filtered levels lag the pins, so a glitch shorter than two samples is lost
  logic [NUM_PINS-1:0] pin_level;

  spp_pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clk  (CLK),
    .srst (SRST),
    .din  (PIN_IN),
    .dout (pin_level)
  );

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [NUM_PINS-1:0] out_latch;
  logic [NUM_PINS-1:0] port_direction;
  logic [NUM_PINS-1:0] analog_select;
  logic [NUM_PINS-1:0] pullup_enable_bits;
  logic [NUM_PINS-1:0] change_int_enable_bits;
  logic [NUM_PINS-1:0] last_read;
  logic [7:0]          interrupt_control;
  logic [7:1]          ic_ctrl;
  logic                port_change_flag;
  logic [7:0]          option_reg;

  // --------------------------------------------------------------------------
  // Strobe decoding
  // --------------------------------------------------------------------------
  // One register's strobe: its enable qualified by a full offset match
  function automatic logic reg_hit(input logic en, input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = en && (addr == ofs);
  endfunction : reg_hit

  wire rd_data = reg_hit(rb.rd_en, rb.rd_addr, `SPP_OFS_PORT_DATA);
  wire wr_data = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_PORT_DATA);
  wire wr_dir  = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_PORT_DIRECTION);
  wire wr_ic   = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_INT_CONTROL);
  wire wr_ana  = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_ANALOG_SELECT);
  wire wr_pu   = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_PULLUP_ENABLE);
  wire wr_chg  = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_CHANGE_ENABLE);
  wire wr_opt  = reg_hit(rb.wr_en, rb.wr_addr, `SPP_OFS_OPTION);
  // Any port_data access, read or write, reloads the last-read latch
  wire port_access = rd_data | wr_data;

  // --------------------------------------------------------------------------
  // Pin read path
  // --------------------------------------------------------------------------
  wire [NUM_PINS-1:0] analog_pins = analog_select & `SPP_ANALOG_PINS_MASK;
  wire [NUM_PINS-1:0] master_clear_pin_mask   = MASTER_CLEAR_ENABLE ? `SPP_INPUT_ONLY_MASK : 6'h00;

  // Digital reads see the pins, blanked by analog select and master clear
  wire [NUM_PINS-1:0] pin_read = pin_level & ~analog_pins
                                 & ~master_clear_pin_mask;

  // --------------------------------------------------------------------------
  // Effective direction
  // --------------------------------------------------------------------------
  // Pins lent to the oscillator stay inputs as far as the port is concerned
  wire [NUM_PINS-1:0] osc_force =
      osc_two_mask |
      osc_one_mask;
  wire [NUM_PINS-1:0] dir_eff = port_direction | `SPP_INPUT_ONLY_MASK
                                | osc_force;

  // Analog select does not touch the driver, so an analog output still drives
  assign PIN_OUT = out_latch;
  assign PIN_OE  = ~dir_eff;

  // --------------------------------------------------------------------------
  // Weak pull-ups
  // --------------------------------------------------------------------------
  wire pullup_global_off = option_reg[`SPP_OPT_PULLUP_DIS_BIT];
  // Analog pins lose their pull-up together with their digital input
  wire [NUM_PINS-1:0] pullup_sw =
      pullup_enable_bits & `SPP_PULLUP_PINS_MASK
      & dir_eff
      & ~analog_pins
      & {NUM_PINS{~pullup_global_off}};
  // The input-only pin's pull-up is owned by the master clear function
  assign PULLUP_EN = pullup_sw | master_clear_pin_mask;

  // --------------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------------
  // Crystal-family modes hide the change enables of the oscillator pins
  wire [NUM_PINS-1:0] chg_eff = change_int_enable_bits & ~osc_two_mask;
  // Analog pins read zero, so they mismatch only while last_read still holds a one from before the select
  wire [NUM_PINS-1:0] mismatch_bits = chg_eff & (pin_read ^ last_read);
  wire                mismatch      = |mismatch_bits;
  // A port access in flight hides the compare, so a change then may be missed
  wire                port_busy     = port_access;
  wire                flag_set      = mismatch & ~port_busy;

  // Read-modify-write: the input-only bit keeps what the pin read showed
  wire [NUM_PINS-1:0] rmw_value = (rb.wdata[NUM_PINS-1:0] & ~`SPP_INPUT_ONLY_MASK)
                                  | (pin_read & `SPP_INPUT_ONLY_MASK);

  // --------------------------------------------------------------------------
  // Read data multiplexer
  // --------------------------------------------------------------------------
  wire [7:0] dir_read = {2'b00, dir_eff};
  wire [7:0] chg_read = {2'b00, chg_eff};
  wire [7:0] pu_read  = {2'b00, pullup_enable_bits & `SPP_PULLUP_PINS_MASK};
  wire [7:0] ana_read = {2'b00, analog_pins};

  // Unmapped offsets read zero; the front end registers the result
  always_comb begin
    case (rb.rd_addr)
      `SPP_OFS_PORT_DATA:      rb.rdata = {2'b00, pin_read};
      `SPP_OFS_PORT_DIRECTION: rb.rdata = dir_read;
      `SPP_OFS_INT_CONTROL:    rb.rdata = interrupt_control;
      `SPP_OFS_ANALOG_SELECT:  rb.rdata = ana_read;
      `SPP_OFS_PULLUP_ENABLE:  rb.rdata = pu_read;
      `SPP_OFS_CHANGE_ENABLE:  rb.rdata = chg_read;
      `SPP_OFS_OPTION:         rb.rdata = option_reg;
      default:                 rb.rdata = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Output latch and direction
  // --------------------------------------------------------------------------
  // The latch is loaded only by a port write, never by a read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      out_latch <= 6'h00;
    end else if (wr_data) begin
      out_latch <= rmw_value;
    end
  end

  // The input-only bit is stored set so no path can ever drive that pin
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_direction <= `SPP_DIRECTION_RST;
    end else if (wr_dir) begin
      port_direction <= rb.wdata[NUM_PINS-1:0] | `SPP_INPUT_ONLY_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Analog select, pull-up enables, change enables, option
  // --------------------------------------------------------------------------
  // Only pins with an analog function keep a select bit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      analog_select <= `SPP_ANALOG_SELECT_RST;
    end else if (wr_ana) begin
      analog_select <= rb.wdata[NUM_PINS-1:0] & `SPP_ANALOG_PINS_MASK;
    end
  end

  // The input-only pin has no software pull-up bit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pullup_enable_bits <= `SPP_PULLUP_ENABLE_RST;
    end else if (wr_pu) begin
      pullup_enable_bits <= rb.wdata[NUM_PINS-1:0] & `SPP_PULLUP_PINS_MASK;
    end
  end

  // Every reset kind clears these, power-on included
  always_ff @(posedge CLK) begin
    if (SRST) begin
      change_int_enable_bits <= `SPP_CHANGE_ENABLE_RST;
    end else if (wr_chg) begin
      change_int_enable_bits <= rb.wdata[NUM_PINS-1:0];
    end
  end

  // Power-on sets the global disable, so every pull-up but the master clear pin's starts off
  always_ff @(posedge CLK) begin
    if (SRST) begin
      option_reg <= `SPP_OPTION_RST;
    end else if (wr_opt) begin
      option_reg <= rb.wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Last-read latch
  // --------------------------------------------------------------------------
  // Only a power-on clears it; other resets leave a pending mismatch visible
  always_ff @(posedge CLK) begin
    if (SRST && POR_RESET) begin
      last_read <= `SPP_LAST_READ_RST;
    end else if (port_access) begin
      last_read <= pin_read;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt control
  // --------------------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  wire ic_flag_wr   = wr_ic ? rb.wdata[`SPP_IC_PORT_FLAG_BIT]
                            : port_change_flag;
  wire next_ic_flag = ic_flag_wr | flag_set;
  // Other resets keep the flag and let a standing mismatch set it again
  wire rst_ic_flag  = ~POR_RESET & (port_change_flag | mismatch);

  // The flag sits at bit zero; the other bits are plain storage
  assign interrupt_control = {ic_ctrl, port_change_flag};

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ic_ctrl <= 7'(`SPP_INT_CONTROL_RST >> 1);
    end else if (wr_ic) begin
      ic_ctrl <= rb.wdata[7:1];
    end
  end

  // The flag survives non power-on resets and keeps setting on a mismatch
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_change_flag <= rst_ic_flag;
    end else begin
      port_change_flag <= next_ic_flag;
    end
  end

  // --------------------------------------------------------------------------
  // Wake and interrupt requests
  // --------------------------------------------------------------------------
  // Both requests are levels that drop once software clears the flag
  // Waking needs only the port enable; vectoring also needs the global enable
  assign WAKE_REQ     = interrupt_control[`SPP_IC_PORT_FLAG_BIT]
                        & interrupt_control[`SPP_IC_PORT_EN_BIT];
  assign PORT_INT_REQ = WAKE_REQ & interrupt_control[`SPP_IC_GLOBAL_EN_BIT];

endmodule : spp_port

`default_nettype wire

// [pkg/spp_cfg.svh]
/*
  Register offsets, field positions, masks and reset values of the six-pin port.
  Assumes a 32-bit AHB-Lite bus with one register to each aligned word.
*/
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SPP_OFS_PORT_DATA      8'h00
`define SPP_OFS_PORT_DIRECTION 8'h04
`define SPP_OFS_INT_CONTROL    8'h08
`define SPP_OFS_ANALOG_SELECT  8'h0C
`define SPP_OFS_PULLUP_ENABLE  8'h10
`define SPP_OFS_CHANGE_ENABLE  8'h14
`define SPP_OFS_OPTION         8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPP_INPUT_ONLY_BIT     3
`define SPP_OSC_PIN_HI_BIT     5
`define SPP_OSC_PIN_LO_BIT     4
`define SPP_IC_GLOBAL_EN_BIT   7
`define SPP_IC_PORT_EN_BIT     3
`define SPP_IC_PORT_FLAG_BIT   0
`define SPP_OPT_PULLUP_DIS_BIT 7

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define SPP_INPUT_ONLY_MASK    6'h08
`define SPP_ANALOG_PINS_MASK   6'h17
`define SPP_PULLUP_PINS_MASK   6'h37
`define SPP_DIRECTION_RST      6'h3F
`define SPP_ANALOG_SELECT_RST  6'h17
`define SPP_PULLUP_ENABLE_RST  6'h37
`define SPP_CHANGE_ENABLE_RST  6'h00
`define SPP_INT_CONTROL_RST    8'h00
`define SPP_OPTION_RST         8'hFF
`define SPP_LAST_READ_RST      6'h00

`endif

// [pkg/spp_pkg.sv]
/*
  Types shared by the six-pin port modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package spp_pkg;
  // Oscillator configuration as the clock block reports it
  typedef enum logic [2:0] {
    SPP_OSC_LOW_POWER,
    SPP_OSC_CRYSTAL,
    SPP_OSC_HIGH_SPEED,
    SPP_OSC_EXT_CLOCK,
    SPP_OSC_INT_IO,
    SPP_OSC_INT_CLKOUT,
    SPP_OSC_RC_WITH_IO,
    SPP_OSC_RC
  } spp_osc_e;
endpackage : spp_pkg

`default_nettype wire

// [pkg/spp_regbus_if.sv]
/*
  Internal register strobe bundle between the bus front end and the port core.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface spp_regbus_if;
  logic       rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wdata;

  modport bus  (output rd_en, output rd_addr, input rdata,
                output wr_en, output wr_addr, output wdata);
  modport regs (input rd_en, input rd_addr, output rdata,
                input wr_en, input wr_addr, input wdata);
endinterface : spp_regbus_if

`default_nettype wire

// [design/spp_pin_sync.sv]
/*
  Three-stage pin synchroniser with a two-stage agreement filter.
  Assumes asynchronous pin levels and one system clock.
*/
`default_nettype none

module spp_pin_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // A change is accepted only once stages two and three agree
      always_ff @(posedge clk) begin
        if (srst) begin
          s1      <= 1'b0;
          s2      <= 1'b0;
          s3      <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1 <= din[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            dout[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : spp_pin_sync

`default_nettype wire

// [design/spp_ahb_slave.sv]
/*
  AHB-Lite slave front end: turns single word transfers into read and write strobes.
  Assumes the slave's hreadyout is the bus hready; it never inserts wait states.
*/
`default_nettype none

module spp_ahb_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // AHB-Lite slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Register strobes
  spp_regbus_if.bus        rb
);
  logic       wr_pend;
  logic [7:0] wr_addr_q;

  // Transfer size is not checked: only whole words are expected
  wire addr_ok = hsel & htrans[1] & hready & (haddr[31:8] == 24'h0) & (hsize == hsize);

  assign rb.rd_en   = addr_ok & ~hwrite;
  assign rb.rd_addr = haddr[7:0];
  assign rb.wr_en   = wr_pend;
  assign rb.wr_addr = wr_addr_q;
  assign rb.wdata   = hwdata[7:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  // ------------------------------------------------------------------------
  // Address phase capture; read data is taken at the address edge
  // ------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend   <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend   <= addr_ok & hwrite;
      wr_addr_q <= haddr[7:0];
      if (rb.rd_en) begin
        hrdata <= {24'h00_0000, rb.rdata};
      end
    end
  end
endmodule : spp_ahb_slave

`default_nettype wire

// [verif/spp_port_sva.sv]
/*
  Concurrent checks on the six-pin port, bound to its top-level ports.
  Assumes one clock domain and the synchronous reset SRST.
*/
`default_nettype none

module spp_port_sva
  import spp_pkg::*;
#(
  parameter int NUM_PINS = 6
) (
  // Clock and reset
  input wire logic                CLK,
  input wire logic                SRST,
  input wire logic                POR_RESET,
  // Bus answer
  input wire logic [31:0]         HRDATA,
  input wire logic                HREADYOUT,
  input wire logic                HRESP,
  // Configuration and pins
  input wire logic                MASTER_CLEAR_ENABLE,
  input wire logic [2:0]          OSC_MODE,
  input wire logic [NUM_PINS-1:0] PIN_OE,
  input wire logic [NUM_PINS-1:0] PULLUP_EN,
  input wire logic                PORT_INT_REQ,
  input wire logic                WAKE_REQ
);
  // --------------------
  // Checks
  // --------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_por_release;
    $fell(SRST) && $past(POR_RESET);
  endsequence
  sequence s_crystal_mode;
    OSC_MODE inside {SPP_OSC_LOW_POWER, SPP_OSC_CRYSTAL, SPP_OSC_HIGH_SPEED};
  endsequence

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
  a_upper_zero: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_pin3_undriven: assert property (!PIN_OE[3])
    else $error("input-only pin driven");
  a_pin3_pullup: assert property (PULLUP_EN[3] == MASTER_CLEAR_ENABLE)
    else $error("input-only pin pull-up not following master clear");
  a_pullup_output: assert property ((PIN_OE & PULLUP_EN) == '0)
    else $error("pull-up on while pin drives");
  a_crystal_inputs: assert property (s_crystal_mode |-> PIN_OE[5:4] == 2'h0)
    else $error("pins five or four driven in crystal mode");
  a_rc_input: assert property
    (OSC_MODE inside {SPP_OSC_EXT_CLOCK, SPP_OSC_RC_WITH_IO, SPP_OSC_RC} |-> !PIN_OE[5])
    else $error("pin five driven in rc or external clock mode");
  a_int_gated: assert property (PORT_INT_REQ |-> WAKE_REQ)
    else $error("interrupt without enabled change flag");
  a_por_quiet: assert property
    (s_por_release |-> !WAKE_REQ && (PULLUP_EN & 6'h37) == 6'h00)
    else $error("pull-up or wake active after power-on");
endmodule : spp_port_sva

bind spp_port spp_port_sva #(.NUM_PINS(NUM_PINS)) u_sva (
  .CLK(CLK), .SRST(SRST), .POR_RESET(POR_RESET), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MASTER_CLEAR_ENABLE(MASTER_CLEAR_ENABLE),
  .OSC_MODE(OSC_MODE), .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN),
  .PORT_INT_REQ(PORT_INT_REQ), .WAKE_REQ(WAKE_REQ));

`default_nettype wire

// [verif/spp_pin_model.sv]
/*
  Package pins and outside circuitry of the six-pin port.
  Assumes the bench sets what the outside drives; floating pins wiggle
  every cycle so a stale value is never mistaken for a level.
*/
`default_nettype none

module spp_pin_model (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pullup_en,
  // Outside drivers
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  // Resolved levels
  output var  logic [5:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] float_q = 6'h15;

  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) level[i] = pin_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pullup_en[i]) level[i] = 1'h1;
      else level[i] = float_q[i];
    end
  end
endmodule : spp_pin_model

`default_nettype wire

// [verif/testbench.sv]
/*
  Self-checking bench of the six-pin port: register rows first, then
  pins, change flag, resets and oscillator modes by hand.
  Assumes the checker is bound and the pin model resolves the pins.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        por = 1'h1;
  logic        master_clear_pin_en = 1'h1;
  logic [2:0]  osc = 3'h4;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  ext_val = 6'h2A;
  logic [5:0]  ext_en = 6'h3F;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, int_req, wake_req;
  logic [5:0]  pin_in, pin_out, pin_oe, pullup_en;
  logic [7:0]  exp_dir;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Row: write flag, offset, write data, expected read
  logic [24:0] rows [16] = '{25'h0_04_00_3F, 25'h0_0C_00_17, 25'h0_10_00_37,
    25'h0_14_00_00, 25'h0_08_00_00, 25'h0_18_00_FF, 25'h0_00_00_20, 25'h1_0C_00_00,
    25'h0_00_00_22, 25'h1_04_F0_38, 25'h1_00_3F_27, 25'h1_18_00_00, 25'h1_14_3F_3F,
    25'h1_08_88_88, 25'h1_40_FF_00, 25'h1_10_FF_37};

  initial begin
    forever #20 clk = ~clk;
  end

  spp_port u_dut (.CLK(clk), .SRST(srst), .POR_RESET(por), .HSEL(1'h1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MASTER_CLEAR_ENABLE(master_clear_pin_en),
    .OSC_MODE(osc), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PULLUP_EN(pullup_en), .PORT_INT_REQ(int_req), .WAKE_REQ(wake_req));
  spp_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .level(pin_in));

  // --------------------
  // Tasks
  // --------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb

  // A read right after a write sees the old value, so let the write settle
  task automatic wrd(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (w) begin
      ahb(1'h1, a, {24'h0, d});
      repeat (5) @(posedge clk);
    end
    ahb(1'h0, a, 32'h0);
  endtask : wrd

  task automatic rst(input logic p);
    por <= p;
    srst <= 1'h1;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : rst

  task automatic arm();
    wrd(1'h1, 8'h0C, 8'h00);
    wrd(1'h1, 8'h14, 8'h3F);
    wrd(1'h1, 8'h08, 8'h08);
  endtask : arm

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  // --------------------
  // Sequence
  // --------------------
  initial begin
    rst(1'h1);
    foreach (rows[i]) begin
      wrd(rows[i][24], rows[i][23:16], rows[i][15:8]);
      chk($sformatf("row %0d", i), rd, {24'h0, rows[i][7:0]});
    end
    chk("pin_out", 32'(pin_out), 32'h37);
    chk("pin_oe", 32'(pin_oe), 32'h07);
    chk("pullup_en", 32'(pullup_en), 32'h38);
    ext_val <= 6'h0A;
    repeat (6) @(posedge clk);
    chk("wake_req", 32'(wake_req), 32'h1);
    chk("int_req", 32'(int_req), 32'h1);
    wrd(1'h1, 8'h08, 8'h88);
    chk("flag held", rd, 32'h89);
    wrd(1'h0, 8'h00, 8'h00);
    chk("port read", rd, 32'h07);
    wrd(1'h1, 8'h08, 8'h88);
    chk("flag cleared", rd, 32'h88);
    wrd(1'h1, 8'h04, 8'h3F);
    wrd(1'h0, 8'h00, 8'h00);
    chk("released read", rd, 32'h02);
    wrd(1'h1, 8'h08, 8'h08);
    rst(1'h0);
    arm();
    chk("wake kept latch", 32'(wake_req), 32'h0);
    rst(1'h1);
    chk("pullups after power-on", 32'(pullup_en), 32'h08);
    arm();
    chk("wake fresh latch", 32'(wake_req), 32'h1);
    wrd(1'h1, 8'h0C, 8'h17);
    wrd(1'h1, 8'h04, 8'h00);
    for (int m = 0; m < 8; m++) begin
      osc <= 3'(m);
      wrd(1'h0, 8'h04, 8'h00);
      exp_dir = (m < 3) ? 8'h38 : (m == 3 || m > 5) ? 8'h28 : 8'h08;
      chk("direction", rd, {24'h0, exp_dir});
      chk("drive enable", 32'(pin_oe), {26'h0, ~exp_dir[5:0]});
    end
    master_clear_pin_en <= 1'h0;
    wrd(1'h0, 8'h00, 8'h00);
    chk("master clear off", rd, 32'h08);
    chk("pin3 pullup", 32'(pullup_en), 32'h00);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
